/* inc/brownout_monitor_defs.vh */
`ifndef BROWNOUT_MONITOR_DEFS_VH
`define BROWNOUT_MONITOR_DEFS_VH

// Register indices (printed offsets); byte address is four times the index
`define IDX_CONTROL_A        8'h00
`define IDX_THRESHOLD        8'h01
`define IDX_RESERVED_LO      8'h02
`define IDX_RESERVED_HI      8'h07
`define IDX_WARN_LEVEL       8'h08
`define IDX_WARN_INT_CTRL    8'h09
`define IDX_WARN_INT_FLAGS   8'h0a
`define IDX_WARN_STATUS      8'h0b
// Index of the unlock key register (not part of the printed map)
`define IDX_UNLOCK_KEY       8'h0f

// Field positions
`define CONTROL_A_SLEEP_LSB  0
`define CONTROL_A_ACTIVE_LSB 2
`define CONTROL_A_SAMPLE_BIT 4
`define THRESHOLD_LEVEL_LSB  0
`define WARN_CTRL_IE_BIT     0
`define WARN_CTRL_DIR_LSB    1
`define FLAG_BIT             0
`define STATUS_BIT           0

// Fuse byte layout: sleep 1:0, active 3:2, sample 4, level 7:5
`define FUSE_SLEEP_LSB       0
`define FUSE_ACTIVE_LSB      2
`define FUSE_SAMPLE_BIT      4
`define FUSE_LEVEL_LSB       5

// Reset values
`define RST_WARN_LEVEL       2'h0
`define RST_WARN_CTRL        2'h0
`define RST_FLAG             1'b0

// Mode encodings
`define MODE_OFF             2'h0
`define MODE_CONTINUOUS      2'h1
`define MODE_SAMPLED         2'h2
`define MODE_HALT_AT_WAKE    2'h3

// Direction encodings
`define DIR_FALLING          2'h0
`define DIR_RISING           2'h1
`define DIR_BOTH             2'h2

// Unlock key and window
// Key value is arbitrary
`define UNLOCK_KEY           8'ha5
`define UNLOCK_WINDOW        3'h4

// Sample timing
`define CLOCK_HZ             10000000
`define SAMPLE_FAST_HZ       128
`define SAMPLE_SLOW_HZ       32
`define SAMPLE_FAST_CYCLES   (`CLOCK_HZ / `SAMPLE_FAST_HZ)
`define SAMPLE_SLOW_CYCLES   (`CLOCK_HZ / `SAMPLE_SLOW_HZ)

// AXI responses
`define RESP_OKAY            2'h0
`define RESP_SLVERR          2'h2

`endif

/* hw/sample_tick.v */
`include "brownout_monitor_defs.vh"

// Sampling strobe: one-cycle pulse at the selected rate
module sample_tick #(
    parameter FAST_CYCLES = `SAMPLE_FAST_CYCLES,
    parameter SLOW_CYCLES = `SAMPLE_SLOW_CYCLES
) (
    input  wire aclk,     // System clock
    input  wire aresetn,  // Synchronous reset, active low
    input  wire run,      // Count only while high
    input  wire slow,     // 0: fast rate, 1: slow rate
    output reg  tick      // One-cycle sample pulse
);
    reg  [19:0] count_q;
    wire [19:0] limit = slow ? SLOW_CYCLES[19:0] - 20'h00001 : FAST_CYCLES[19:0] - 20'h00001;

    always @(posedge aclk) begin
        if (!aresetn) begin
            count_q <= 20'h00000;
            tick    <= 1'b0;
        end else if (!run) begin
            count_q <= 20'h00000;
            tick    <= 1'b0;
        end else if (count_q >= limit) begin
            count_q <= 20'h00000;
            tick    <= 1'b1;
        end else begin
            count_q <= count_q + 20'h00001;
            tick    <= 1'b0;
        end
    end
endmodule

/* hw/brownout_monitor_regs.v */
// Operation
// R1: Sample bit picks 128 Hz or 32 Hz
// R2: Sample bit loaded from fuse, read-only
// R3: Sample bit needs no unlock
// R4: Active mode field, bits 3:2, read-only
// R5: Active codes: off, continuous, sampled, halt-wake
// R6: Active mode loaded from fuse
// R7: Sleep mode field bits 1:0, writable
// R8: Sleep mode loaded from fuse, overwritable
// R9: Threshold 3 bits read-only, upper zero
// R10: Threshold loaded from fuse level bits
// R11: Warning level off, 5, 15, 25 percent
// R12: Direction: falling, rising, both; 3 reserved
// R13: Interrupt enable is bit 0
// R14: Matching crossing sets warning flag
// R15: Flag updates only while detector enabled
// R16: Status 0 above, 1 below threshold
// R17: Software ignores status while detector off
// R18: Sleep mode in standby, active on wake
// R19: Sleep field write needs recent unlock
// R20: Irq high while enable and flag set
// R21: Monitor follows detector mode and sampling
// R22: Writing one clears flag
// R23: Unused bits and reserved offsets read zero
`include "brownout_monitor_defs.vh"

module brownout_monitor_regs #(
    parameter FAST_CYCLES = `SAMPLE_FAST_CYCLES,
    parameter SLOW_CYCLES = `SAMPLE_SLOW_CYCLES
) (
    input  wire        aclk,                 // System clock, 10 MHz
    input  wire        aresetn,              // Synchronous reset, active low
    input  wire [7:0]  detector_config_fuse, // Fuse byte, stable at reset release
    input  wire        deep_sleep,           // Standby or power-down entered
    input  wire        below_warning_raw,    // Monitor comparator, 1 = below threshold
    input  wire [7:0]  awaddr,               // AXI write address
    input  wire        awvalid,              // AXI write address valid
    output wire        awready,              // AXI write address ready
    input  wire [31:0] wdata,                // AXI write data
    input  wire [3:0]  wstrb,                // AXI write strobes
    input  wire        wvalid,               // AXI write data valid
    output wire        wready,               // AXI write data ready
    output reg  [1:0]  bresp,                // AXI write response
    output reg         bvalid,               // AXI write response valid
    input  wire        bready,               // AXI write response ready
    input  wire [7:0]  araddr,               // AXI read address
    input  wire        arvalid,              // AXI read address valid
    output wire        arready,              // AXI read address ready
    output reg  [31:0] rdata,                // AXI read data
    output reg  [1:0]  rresp,                // AXI read response
    output reg         rvalid,               // AXI read data valid
    input  wire        rready,               // AXI read data ready
    output reg  [1:0]  detector_mode,        // Mode in force for the analog detector
    output reg  [2:0]  brownout_threshold_level, // Threshold code to the analog detector
    output reg  [1:0]  warning_threshold_offset, // Warning offset code to the monitor
    output reg         sample_strobe,        // Sample pulse, only in sampled mode with monitor on
    output reg         monitor_active,       // Monitor powered
    output reg         halt_until_ready,     // Hold execution at wake-up
    output reg         warning_irq           // Interrupt request level
);
    localparam ST_IDLE = 2'b01;
    localparam ST_RESP = 2'b10;

    // Fuse-loaded fields
    reg        sample_rate_select_q;
    reg [1:0]  active_mode_q;
    reg [1:0]  sleep_mode_q;
    reg [2:0]  threshold_q;
    reg        fuse_loaded_q;
    // Software fields
    reg [1:0]  warn_level_q;
    reg [1:0]  warning_direction_select_q;
    reg        warning_irq_enable_q;
    reg        warning_irq_flag_q;
    reg        warning_level_state_q;
    reg [2:0]  unlock_cnt_q;
    // Synchronisers
    reg        below_s1_q;
    reg        below_s2_q;
    reg        sleep_s1_q;
    reg        sleep_s2_q;
    reg        below_prev_q;
    // Bus
    reg [1:0]  wstate_q;
    reg        aw_held_q;
    reg [7:0]  aw_addr_q;
    reg        w_held_q;
    reg [31:0] w_data_q;
    reg [3:0]  w_strb_q;

    wire [1:0] mode_now = sleep_s2_q ? sleep_mode_q : active_mode_q; // R18
    wire       enabled  = (mode_now != `MODE_OFF);
    wire       sampled  = (mode_now == `MODE_SAMPLED);
    wire       mon_on   = enabled && (warn_level_q != `RST_WARN_LEVEL); // R21
    wire       tick;

    sample_tick #(
        .FAST_CYCLES (FAST_CYCLES),
        .SLOW_CYCLES (SLOW_CYCLES)
    ) u_tick (
        .aclk    (aclk),
        .aresetn (aresetn),
        .run     (mon_on && sampled),
        .slow    (sample_rate_select_q), // R1
        .tick    (tick)
    );

    // Continuous mode samples every cycle; sampled mode on the strobe
    wire take = mon_on && (sampled ? tick : 1'b1); // R21

    function [7:0] reg_index;
        input [7:0] addr;
        begin
            reg_index = {2'b00, addr[7:2]};
        end
    endfunction

    function is_mapped;
        input [7:0] idx;
        begin
            is_mapped = (idx <= `IDX_WARN_STATUS) || (idx == `IDX_UNLOCK_KEY); // R23
        end
    endfunction

    wire both_held = aw_held_q && w_held_q;
    assign awready = (wstate_q == ST_IDLE) && !aw_held_q;
    assign wready  = (wstate_q == ST_IDLE) && !w_held_q;
    assign arready = !rvalid;

    wire [7:0] widx    = reg_index(aw_addr_q);
    wire       wr_do   = (wstate_q == ST_IDLE) && both_held && w_strb_q[0];
    wire [7:0] wbyte   = w_data_q[7:0];
    wire       clr_hit = wr_do && (widx == `IDX_WARN_INT_FLAGS) && wbyte[`FLAG_BIT];

    // Crossing detection
    wire fell     = take && below_s2_q && !below_prev_q;
    wire rose     = take && !below_s2_q && below_prev_q;
    reg  crossing;
    always @* begin
        case (warning_direction_select_q) // R12
            `DIR_FALLING: crossing = fell;
            `DIR_RISING:  crossing = rose;
            `DIR_BOTH:    crossing = fell || rose;
            default:      crossing = 1'b0;
        endcase
    end

    // Fuse load and pin synchronisers
    always @(posedge aclk) begin
        if (!aresetn) begin
            fuse_loaded_q        <= 1'b0;
            sample_rate_select_q <= 1'b0;
            active_mode_q        <= `MODE_OFF;
            threshold_q          <= 3'h0;
            below_s1_q           <= 1'b0;
            below_s2_q           <= 1'b0;
            sleep_s1_q           <= 1'b0;
            sleep_s2_q           <= 1'b0;
        end else begin
            below_s1_q <= below_warning_raw;
            below_s2_q <= below_s1_q;
            sleep_s1_q <= deep_sleep;
            sleep_s2_q <= sleep_s1_q;
            // Caught once after reset release; the fuse is static then
            if (!fuse_loaded_q) begin
                fuse_loaded_q        <= 1'b1;
                sample_rate_select_q <= detector_config_fuse[`FUSE_SAMPLE_BIT];            // R2 R3
                active_mode_q        <= detector_config_fuse[`FUSE_ACTIVE_LSB +: 2];       // R4 R6
                threshold_q          <= detector_config_fuse[`FUSE_LEVEL_LSB +: 3];        // R9 R10
            end
        end
    end

    // Software-facing state
    always @(posedge aclk) begin
        if (!aresetn) begin
            sleep_mode_q               <= `MODE_OFF;
            warn_level_q               <= `RST_WARN_LEVEL;
            warning_direction_select_q <= `RST_WARN_CTRL;
            warning_irq_enable_q       <= 1'b0;
            warning_irq_flag_q         <= `RST_FLAG;
            warning_level_state_q      <= 1'b0;
            below_prev_q               <= 1'b0;
            unlock_cnt_q               <= 3'h0;
        end else begin
            if (!fuse_loaded_q)
                sleep_mode_q <= detector_config_fuse[`FUSE_SLEEP_LSB +: 2]; // R8
            if (take) begin
                warning_level_state_q <= below_s2_q; // R16
                below_prev_q          <= below_s2_q;
            end
            // Unlock window counts register writes after the key
            if (wr_do && widx == `IDX_UNLOCK_KEY && wbyte == `UNLOCK_KEY)
                unlock_cnt_q <= `UNLOCK_WINDOW;
            else if (wr_do && unlock_cnt_q != 3'h0)
                unlock_cnt_q <= unlock_cnt_q - 3'h1;
            if (wr_do) begin
                case (widx)
                    `IDX_CONTROL_A:
                        if (unlock_cnt_q != 3'h0 && wbyte[`CONTROL_A_SLEEP_LSB +: 2] != `MODE_HALT_AT_WAKE) begin // R19
                            sleep_mode_q <= wbyte[`CONTROL_A_SLEEP_LSB +: 2]; // R7
                        end
                    `IDX_WARN_LEVEL:
                        warn_level_q <= wbyte[1:0]; // R11
                    `IDX_WARN_INT_CTRL: begin
                        warning_irq_enable_q       <= wbyte[`WARN_CTRL_IE_BIT];        // R13
                        warning_direction_select_q <= wbyte[`WARN_CTRL_DIR_LSB +: 2];  // R12
                    end
                    default: ;
                endcase
            end
            // Set wins over a clear in the same cycle; never set while detector off, a write of one still clears it
            if (enabled && crossing)
                warning_irq_flag_q <= 1'b1; // R14 R15
            else if (clr_hit)
                warning_irq_flag_q <= 1'b0; // R22
        end
    end

    // Write channel
    always @(posedge aclk) begin
        if (!aresetn) begin
            wstate_q  <= ST_IDLE;
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q  <= 32'h00000000;
            w_strb_q  <= 4'h0;
            bvalid    <= 1'b0;
            bresp     <= `RESP_OKAY;
        end else begin
            case (wstate_q)
                ST_IDLE: begin
                    if (awvalid && awready) begin
                        aw_held_q <= 1'b1;
                        aw_addr_q <= awaddr;
                    end
                    if (wvalid && wready) begin
                        w_held_q <= 1'b1;
                        w_data_q <= wdata;
                        w_strb_q <= wstrb;
                    end
                    if (both_held) begin
                        bvalid    <= 1'b1;
                        bresp     <= is_mapped(widx) ? `RESP_OKAY : `RESP_SLVERR;
                        aw_held_q <= 1'b0;
                        w_held_q  <= 1'b0;
                        wstate_q  <= ST_RESP;
                    end
                end
                ST_RESP:
                    if (bready) begin
                        bvalid   <= 1'b0;
                        wstate_q <= ST_IDLE;
                    end
                default:
                    wstate_q <= ST_IDLE;
            endcase
        end
    end

    // Read channel
    reg [7:0] rbyte;
    wire [7:0] ridx = reg_index(araddr);
    always @* begin
        case (ridx) // R23
            `IDX_CONTROL_A:      rbyte = {3'b000, sample_rate_select_q, active_mode_q, sleep_mode_q};
            `IDX_THRESHOLD:      rbyte = {5'b00000, threshold_q};
            `IDX_WARN_LEVEL:     rbyte = {6'b000000, warn_level_q};
            `IDX_WARN_INT_CTRL:  rbyte = {5'b00000, warning_direction_select_q, warning_irq_enable_q};
            `IDX_WARN_INT_FLAGS: rbyte = {7'b0000000, warning_irq_flag_q};
            `IDX_WARN_STATUS:    rbyte = {7'b0000000, warning_level_state_q}; // R17
            default:             rbyte = 8'h00;
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata  <= 32'h00000000;
            rresp  <= `RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata  <= {24'h000000, rbyte};
            rresp  <= is_mapped(ridx) ? `RESP_OKAY : `RESP_SLVERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    // Outputs to the analog side
    always @(posedge aclk) begin
        if (!aresetn) begin
            detector_mode            <= `MODE_OFF;
            brownout_threshold_level <= 3'h0;
            warning_threshold_offset <= 2'h0;
            sample_strobe            <= 1'b0;
            monitor_active           <= 1'b0;
            halt_until_ready         <= 1'b0;
            warning_irq              <= 1'b0;
        end else begin
            detector_mode            <= mode_now; // R5 R18
            brownout_threshold_level <= threshold_q;
            warning_threshold_offset <= warn_level_q;
            sample_strobe            <= tick;
            monitor_active           <= mon_on;
            halt_until_ready         <= (active_mode_q == `MODE_HALT_AT_WAKE); // R5
            warning_irq              <= warning_irq_enable_q && warning_irq_flag_q; // R20
        end
    end
endmodule

/* verification/brownout_monitor_sva.sv */
`include "brownout_monitor_defs.vh"

module brownout_monitor_sva #(
    parameter FAST_CYCLES = 8,
    parameter SLOW_CYCLES = 16
) (
    input logic        aclk,                     // Clock
    input logic        aresetn,                  // Reset, active low
    input logic [7:0]  detector_config_fuse,     // Fuse byte
    input logic        deep_sleep,               // Standby request
    input logic [7:0]  araddr,                   // Read address
    input logic        arvalid,                  // Read address valid
    input logic        arready,                  // Read address ready
    input logic [31:0] rdata,                    // Read data
    input logic [1:0]  rresp,                    // Read response
    input logic        rvalid,                   // Read data valid
    input logic [1:0]  detector_mode,            // Mode in force
    input logic [2:0]  brownout_threshold_level, // Threshold code
    input logic [1:0]  warning_threshold_offset, // Warning offset
    input logic        sample_strobe,            // Sample pulse
    input logic        monitor_active,           // Monitor powered
    input logic        halt_until_ready          // Wake halt
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0]  cnt_q;
    logic [5:0]  idx_q;
    logic [31:0] gap_q;
    logic        have_q;
    wire  [31:0] period = detector_config_fuse[4] ? SLOW_CYCLES : FAST_CYCLES;
    // Gap is only judged between two strobes that both fell in sampled mode
    always @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q  <= 3'h0;
            idx_q  <= 6'h00;
            gap_q  <= 32'h0;
            have_q <= 1'b0;
        end else begin
            if (cnt_q != 3'h7) cnt_q <= cnt_q + 3'h1;
            if (arvalid && arready) idx_q <= araddr[7:2];
            gap_q  <= sample_strobe ? 32'h0 : gap_q + 32'h1;
            have_q <= (detector_mode == 2'h2) && (sample_strobe || have_q);
        end
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence awake_s;
        (!deep_sleep && cnt_q == 3'h7) [*5];
    endsequence
    sequence level_off_s;
        (warning_threshold_offset == 2'h0) [*2];
    endsequence
    sequence detector_off_s;
        (detector_mode == 2'h0) [*2];
    endsequence
    threshold_read_a: assert property (rvalid && idx_q == 6'h01 |->
        rdata == {29'h0, detector_config_fuse[7:5]}) else $error("threshold read wrong");
    fuse_level_a: assert property (cnt_q >= 3'h3 |->
        brownout_threshold_level == detector_config_fuse[7:5]) else $error("threshold output wrong");
    control_read_a: assert property (rvalid && idx_q == 6'h00 |->
        rdata[31:2] == {27'h0, detector_config_fuse[4:2]}) else $error("control read wrong");
    reserved_read_a: assert property (rvalid && idx_q >= 6'h02 && idx_q <= 6'h07 |->
        rdata == 32'h0 && rresp == `RESP_OKAY) else $error("reserved read wrong");
    unmapped_read_a: assert property (rvalid && idx_q > 6'h0b && idx_q != 6'h0f |->
        rdata == 32'h0 && rresp == `RESP_SLVERR) else $error("unmapped read wrong");
    active_mode_a: assert property (awake_s |->
        detector_mode == detector_config_fuse[3:2]) else $error("awake mode wrong");
    halt_wake_a: assert property (cnt_q == 3'h7 |->
        halt_until_ready == (detector_config_fuse[3:2] == 2'h3)) else $error("halt output wrong");
    level_off_a: assert property (level_off_s |-> !monitor_active) else $error("monitor on at level zero");
    detector_off_a: assert property (detector_off_s |-> !monitor_active) else $error("monitor on, detector off");
    sample_period_a: assert property (sample_strobe && have_q && detector_mode == 2'h2 |->
        gap_q == period - 32'h1) else $error("sample period wrong");
endmodule

bind brownout_monitor_regs brownout_monitor_sva #(.FAST_CYCLES(FAST_CYCLES), .SLOW_CYCLES(SLOW_CYCLES)) u_sva (
    .aclk, .aresetn, .detector_config_fuse, .deep_sleep, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .detector_mode, .brownout_threshold_level, .warning_threshold_offset, .sample_strobe,
    .monitor_active, .halt_until_ready);

/* verification/brownout_monitor_regs_test.sv */
`include "brownout_monitor_defs.vh"

module brownout_monitor_regs_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic        aclk = 1'b0, aresetn = 1'b0, deep_sleep = 1'b0, below_warning_raw = 1'b0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b1, arvalid = 1'b0, rready = 1'b1;
    logic [7:0]  detector_config_fuse = 8'h00, awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, seed = 32'd79548, rd_q;
    logic [3:0]  wstrb = 4'hf;
    logic [1:0]  resp_q;
    wire         awready, wready, bvalid, arready, rvalid, sample_strobe, monitor_active;
    wire         halt_until_ready, warning_irq;
    wire  [1:0]  bresp, rresp, detector_mode, warning_threshold_offset;
    wire  [2:0]  brownout_threshold_level;
    wire  [31:0] rdata;
    int          err_total = 0, comparisons = 0;

    always #50 aclk = ~aclk;

    brownout_monitor_regs #(.FAST_CYCLES(8), .SLOW_CYCLES(16)) u_brownout_monitor_regs (
        .aclk, .aresetn, .detector_config_fuse, .deep_sleep, .below_warning_raw, .awaddr, .awvalid,
        .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
        .arready, .rdata, .rresp, .rvalid, .rready, .detector_mode, .brownout_threshold_level,
        .warning_threshold_offset, .sample_strobe, .monitor_active, .halt_until_ready, .warning_irq);

    function logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task complete_run();
        $display("mismatches %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task stall();
        err_total++;
        $display("CHECK FAILED handshake expected answer seen none");
        complete_run();
    endtask

    // Upper data bits are random so that ignored bits get exercised too
    task wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] r;
        int n;
        r = xs();
        awaddr <= {idx[5:0], 2'b00};
        wdata <= {r[31:8], d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        if (n == 40) stall();
        resp_q = bresp;
    endtask

    task rd(input logic [7:0] idx);
        int n;
        araddr <= {idx[5:0], 2'b00};
        arvalid <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        if (n == 40) stall();
        rd_q = rdata;
        resp_q = rresp;
    endtask

    task rst(input logic [7:0] f);
        aresetn <= 1'b0;
        detector_config_fuse <= f;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
    endtask

    initial begin
        int i;
        logic [31:0] r;
        logic [7:0] f;
        logic [1:0] s, sl;
        logic ex;
        // Every active code with both sample rates; the sample gap is judged by the checker
        for (i = 0; i < 8; i++) begin
            r = xs();
            f = {r[7:5], i[2:0], r[1:0]};
            rst(f);
            rd(`IDX_CONTROL_A);
            chk("control_a", rd_q, {27'h0, f[4:0]});
            rd(`IDX_THRESHOLD);
            chk("threshold", rd_q, {29'h0, f[7:5]});
            chk("halt", {31'h0, halt_until_ready}, {31'h0, i[1:0] == 2'h3});
            chk("mode", {30'h0, detector_mode}, {30'h0, f[3:2]});
            wr(`IDX_CONTROL_A, ~f);
            chk("wr_resp", {30'h0, resp_q}, {30'h0, `RESP_OKAY});
            rd(`IDX_CONTROL_A);
            chk("locked_write", rd_q, {27'h0, f[4:0]});
            // Monitor on, so that sampled codes make strobes for the checker
            wr(`IDX_WARN_LEVEL, 8'h01);
            repeat (40) @(posedge aclk);
        end
        r = xs();
        f = {r[7:5], r[4], 2'h1, r[1:0]};
        rst(f);
        sl = f[1:0];
        for (i = 0; i < 4; i++) begin
            s = 2'h3 - i[1:0];
            if (s != 2'h3) sl = s;
            wr(`IDX_UNLOCK_KEY, `UNLOCK_KEY);
            wr(`IDX_CONTROL_A, {6'h3f, s});
            rd(`IDX_CONTROL_A);
            chk("sleep_field", rd_q, {27'h0, f[4:2], sl});
            deep_sleep <= 1'b1;
            repeat (40) @(posedge aclk);
            chk("sleep_mode", {30'h0, detector_mode}, {30'h0, sl});
            deep_sleep <= 1'b0;
            repeat (6) @(posedge aclk);
            chk("wake_mode", {30'h0, detector_mode}, 32'h1);
        end
        // Key followed by four other writes: the fifth write is too late
        wr(`IDX_UNLOCK_KEY, `UNLOCK_KEY);
        repeat (4) wr(`IDX_WARN_LEVEL, 8'h00);
        wr(`IDX_CONTROL_A, 8'h01);
        rd(`IDX_CONTROL_A);
        chk("late_unlock", rd_q, {27'h0, f[4:2], 2'h0});
        for (i = 0; i < 4; i++) begin
            r = xs();
            wr(`IDX_WARN_LEVEL, {r[7:2], i[1:0]});
            rd(`IDX_WARN_LEVEL);
            chk("warn_level", rd_q, {30'h0, i[1:0]});
            chk("warn_offset", {30'h0, warning_threshold_offset}, {30'h0, i[1:0]});
        end
        // A write without the low byte lane must leave the register alone
        wstrb <= 4'he;
        wr(`IDX_WARN_LEVEL, 8'h00);
        wstrb <= 4'hf;
        rd(`IDX_WARN_LEVEL);
        chk("strobe_off", rd_q, 32'h3);
        for (i = 0; i < 4; i++) begin
            r = xs();
            below_warning_raw <= 1'b0;
            repeat (6) @(posedge aclk);
            wr(`IDX_WARN_INT_CTRL, {r[7:3], i[1:0], r[0]});
            wr(`IDX_WARN_INT_FLAGS, 8'h01);
            rd(`IDX_WARN_INT_CTRL);
            chk("int_ctrl", rd_q, {29'h0, i[1:0], r[0]});
            below_warning_raw <= 1'b1;
            repeat (6) @(posedge aclk);
            ex = (i == 0 || i == 2);
            rd(`IDX_WARN_INT_FLAGS);
            chk("fall_flag", rd_q, {31'h0, ex});
            rd(`IDX_WARN_STATUS);
            chk("status_below", rd_q, 32'h1);
            chk("irq", {31'h0, warning_irq}, {31'h0, ex & r[0]});
            wr(`IDX_WARN_INT_FLAGS, 8'h00);
            rd(`IDX_WARN_INT_FLAGS);
            chk("flag_kept", rd_q, {31'h0, ex});
            wr(`IDX_WARN_INT_FLAGS, 8'h01);
            below_warning_raw <= 1'b0;
            repeat (6) @(posedge aclk);
            rd(`IDX_WARN_INT_FLAGS);
            chk("rise_flag", rd_q, {31'h0, i == 1 || i == 2});
            rd(`IDX_WARN_STATUS);
            chk("status_above", rd_q, 32'h0);
        end
        // Standby with the detector off: a crossing must leave the flag alone
        wr(`IDX_WARN_INT_FLAGS, 8'h01);
        deep_sleep <= 1'b1;
        repeat (6) @(posedge aclk);
        below_warning_raw <= 1'b1;
        repeat (6) @(posedge aclk);
        rd(`IDX_WARN_INT_FLAGS);
        chk("flag_held", rd_q, 32'h0);
        deep_sleep <= 1'b0;
        for (i = 0; i < 8; i++) begin
            r = xs();
            rd(8'h02 + r[7:0] % 8'h06);
            chk("reserved", {rd_q[29:0], resp_q}, {30'h0, `RESP_OKAY});
            rd(8'h10 + r[15:8] % 8'h30);
            chk("unmapped", {rd_q[29:0], resp_q}, {30'h0, `RESP_SLVERR});
            wr(8'h10 + r[23:16] % 8'h30, r[31:24]);
            chk("wr_unmapped", {30'h0, resp_q}, {30'h0, `RESP_SLVERR});
        end
        complete_run();
    end
endmodule
